// ===== hdl/power_handshake_pkg.sv
// Shared constants and state types for the deep-sleep power handshake
package power_handshake_pkg;
    // Suspend clock is the buffered real-time clock; modelled as a divided enable
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RTC_DIV = 8;
    localparam logic [3:0] RTC_DIV_LAST = 4'(RTC_DIV - 1);
    // Debounce interval in suspend clock half-periods (enable pulses)
    localparam int unsigned DEBOUNCE_TICKS = 4;
    localparam logic [7:0] DEBOUNCE_LAST = 8'(DEBOUNCE_TICKS - 1);
    // Partner preparation time in core clocks
    localparam logic [7:0] PREP_CYCLES = 8'h10;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_WARN,
        ST_DEEP,
        ST_EXIT_WAIT,
        ST_HOLDOFF,
        ST_RESET_WAIT
    } sleep_state_e;
endpackage

// ===== hdl/power_handshake_if.sv
// Pin-level link between the hub's suspend logic and the power controller
`timescale 1ns/100ps
`default_nettype none
interface power_handshake_if;
    logic deep_sleep_indicator_n;
    logic suspend_warning_n;
    logic suspend_warning_oe;
    logic engine_powerdown_ack;
    logic suspend_acknowledge_n;
    logic rtc_buffered_clock_out;
    logic sleep_exit_holdoff_n;
    logic system_power_good;
    logic system_reset_request_n;
    logic soft_off_power_control_n;
    // Shared pin: the hub drives it whenever oe is high
    logic shared_pin;
    assign shared_pin = suspend_warning_oe ?
        (suspend_warning_n) : 1'b1;

    modport hub (
        output deep_sleep_indicator_n,
        output suspend_warning_n,
        output suspend_warning_oe,
        output engine_powerdown_ack,
        input suspend_acknowledge_n,
        output rtc_buffered_clock_out,
        input sleep_exit_holdoff_n,
        input system_power_good,
        input system_reset_request_n,
        output soft_off_power_control_n
    );
    modport controller (
        input deep_sleep_indicator_n,
        input suspend_warning_n,
        input suspend_warning_oe,
        input engine_powerdown_ack,
        output suspend_acknowledge_n,
        input rtc_buffered_clock_out,
        output sleep_exit_holdoff_n,
        output system_power_good,
        output system_reset_request_n,
        input soft_off_power_control_n
    );
endinterface
`default_nettype wire

// ===== hdl/power_controller_end.sv
// Embedded-controller end: answers the warning handshake and drives hold-off
`timescale 1ns/100ps
`default_nettype none
module power_controller_end (
    input wire logic core_clk,
    input wire logic sys_rst,
    power_handshake_if.controller link,
    input wire logic deep_sleep_supported,
    input wire logic handshake_bypass,
    input wire logic hold_exit,
    input wire logic power_good_in,
    input wire logic reset_button,
    output logic prepare_power_loss,
    output logic prepare_wake,
    output logic primary_power_enable
);
    logic warn_s1_reg, warn_s2_reg, warn_d_reg;
    logic dsi_s1_reg, dsi_s2_reg;
    logic ack_reg;
    logic [7:0] prep_cnt_reg;
    logic busy_reg;
    logic hold_reg, pg_reg, rst_reg;

    wire warn_fall = warn_d_reg & ~warn_s2_reg;
    wire warn_rise = ~warn_d_reg & warn_s2_reg;
    wire warn_edge = warn_fall | warn_rise;
    wire prep_done = busy_reg && prep_cnt_reg == 8'h00;

    // Bypass ties acknowledge to warning combinationally, like a board strap
    assign link.suspend_acknowledge_n = handshake_bypass ? link.suspend_warning_n : ack_reg;
    assign link.sleep_exit_holdoff_n = ~hold_reg;
    assign link.system_power_good = pg_reg;
    assign link.system_reset_request_n = ~rst_reg;

    always_ff @(posedge core_clk) begin
        warn_s1_reg <= link.suspend_warning_n;
        warn_s2_reg <= warn_s1_reg;
        dsi_s1_reg <= link.deep_sleep_indicator_n;
        dsi_s2_reg <= dsi_s1_reg;
        hold_reg <= hold_exit;
        pg_reg <= power_good_in;
        rst_reg <= reset_button;
        if (sys_rst) begin
            warn_d_reg <= 1'b1;
            ack_reg <= 1'b1;
            busy_reg <= 1'b0;
            prep_cnt_reg <= 8'h00;
            prepare_power_loss <= 1'b0;
            prepare_wake <= 1'b0;
            primary_power_enable <= 1'b0;
        end else begin
            warn_d_reg <= warn_s2_reg;
            primary_power_enable <= dsi_s2_reg;
            prepare_power_loss <= warn_fall;
            prepare_wake <= warn_rise;
            if (warn_edge && deep_sleep_supported) begin
                busy_reg <= 1'b1;
                prep_cnt_reg <= power_handshake_pkg::PREP_CYCLES;
            end else if (prep_done) begin
                busy_reg <= 1'b0;
                ack_reg <= warn_s2_reg;
            end else if (busy_reg) begin
                prep_cnt_reg <= prep_cnt_reg - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/power_hub_end.sv
// Hub end: deep-sleep sequencing, warning handshake, reset debounce
`timescale 1ns/100ps
`default_nettype none
module power_hub_end #(
    parameter logic [7:0] DEBOUNCE_LAST = power_handshake_pkg::DEBOUNCE_LAST
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    power_handshake_if.hub link,
    input wire logic deep_sleep_supported,
    input wire logic espi_enabled,
    input wire logic enter_deep_sleep,
    input wire logic soft_off_state,
    input wire logic engine_sleep_control_n,
    input wire logic engine_needs_primary,
    input wire logic wake_event,
    output logic wake_serviced,
    output logic flash_share_request,
    output logic internal_reset,
    output logic sleep_exit_done,
    output logic [2:0] sleep_state
);
    // ==========================================================
    // Pin synchronisers
    // Board pins cross into this domain; only the second flop is read
    logic ack_s1_reg, ack_s2_reg, hold_s1_reg, hold_s2_reg;
    logic pg_s1_reg, pg_s2_reg, rr_s1_reg, rr_s2_reg;
    logic slp_s1_reg, slp_s2_reg;
    always_ff @(posedge core_clk) begin
        ack_s1_reg <= link.suspend_acknowledge_n;
        ack_s2_reg <= ack_s1_reg;
        hold_s1_reg <= link.sleep_exit_holdoff_n;
        hold_s2_reg <= hold_s1_reg;
        pg_s1_reg <= link.system_power_good;
        pg_s2_reg <= pg_s1_reg;
        rr_s1_reg <= link.system_reset_request_n;
        rr_s2_reg <= rr_s1_reg;
        slp_s1_reg <= engine_sleep_control_n;
        slp_s2_reg <= slp_s1_reg;
    end

    // ==========================================================
    // Suspend clock: toggle on each divider enable
    // One tick per half period, so the output is a clean square wave
    logic [3:0] div_reg;
    logic rtc_buffered_clock_out_reg;
    wire rtc_tick = div_reg == power_handshake_pkg::RTC_DIV_LAST;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_reg <= 4'h0;
            rtc_buffered_clock_out_reg <= 1'b0;
        end else begin
            div_reg <= rtc_tick ? 4'h0 : div_reg + 4'h1;
            if (rtc_tick) rtc_buffered_clock_out_reg <= ~rtc_buffered_clock_out_reg;
        end
    end
    assign link.rtc_buffered_clock_out = rtc_buffered_clock_out_reg;

    // ==========================================================
    // Reset debounce, counted on suspend clock ticks
    // Any bounce restarts the count, so a short glitch never reaches
    // the debounced level
    logic [7:0] deb_cnt_reg;
    logic deb_level_reg;
    wire deb_differs = (~rr_s2_reg) != deb_level_reg;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            deb_cnt_reg <= 8'h00;
            deb_level_reg <= 1'b0;
        end else if (!deb_differs) begin
            deb_cnt_reg <= 8'h00;
        end else if (rtc_tick) begin
            if (deb_cnt_reg == DEBOUNCE_LAST) begin
                deb_level_reg <= ~rr_s2_reg;
                deb_cnt_reg <= 8'h00;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Sleep sequencer
    power_handshake_pkg::sleep_state_e state_reg, state_next;
    wire acked = ack_s2_reg == 1'b0;
    wire warn_active = state_reg == power_handshake_pkg::ST_WARN
        || state_reg == power_handshake_pkg::ST_DEEP;
    wire engine_released = slp_s2_reg;
    wire power_ready = pg_s2_reg;
    // High level on the hold-off pin means the board no longer delays exit
    wire hold_released = hold_s2_reg;
    wire wake_blocked = warn_active && !acked;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            power_handshake_pkg::ST_ACTIVE:
                // Platforms without deepest sleep never leave active here
                if (enter_deep_sleep && deep_sleep_supported) begin
                    state_next = power_handshake_pkg::ST_WARN;
                end
            power_handshake_pkg::ST_WARN:
                if (acked) state_next = power_handshake_pkg::ST_DEEP;
            power_handshake_pkg::ST_DEEP:
                // Leaving raises the warning, which starts the wake preparation
                if (!enter_deep_sleep) state_next = power_handshake_pkg::ST_EXIT_WAIT;
            power_handshake_pkg::ST_EXIT_WAIT:
                // Wait for the controller to finish preparing the primary well
                if (!acked) state_next = power_handshake_pkg::ST_HOLDOFF;
            power_handshake_pkg::ST_HOLDOFF:
                // Hold-off only counts once the engine has released sleep
                if (engine_released && hold_released) begin
                    state_next = power_handshake_pkg::ST_RESET_WAIT;
                end
            power_handshake_pkg::ST_RESET_WAIT:
                if (power_ready) state_next = power_handshake_pkg::ST_ACTIVE;
        endcase
    end

    // A debounced reset request overrides every state, not only active
    always_ff @(posedge core_clk) begin
        if (sys_rst || deb_level_reg) begin
            state_reg <= power_handshake_pkg::ST_RESET_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Output decode
    logic dsi_reg, warn_reg, oe_reg, pdack_reg, s5_reg;
    wire in_deep = state_reg == power_handshake_pkg::ST_DEEP;
    wire in_reset_wait = state_reg == power_handshake_pkg::ST_RESET_WAIT;
    wire warn_pin_n = !warn_active;
    wire pdack_level = !engine_needs_primary;
    // Same pin carries warning or power-down ack by platform type
    wire shared_next = deep_sleep_supported ? warn_pin_n : pdack_level;
    wire dsi_next = !in_deep;
    wire s5_next = !soft_off_state;
    wire wake_next = wake_event && !wake_blocked;
    // Flash sharing is dropped under eSPI; hold-off still gates exit above
    wire flash_next = !espi_enabled && !hold_s2_reg;
    wire int_rst_next = deb_level_reg || in_reset_wait;
    wire exit_done_next = in_reset_wait && power_ready;
    wire [2:0] state_code = state_reg;

    // ==========================================================
    // Pin outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dsi_reg <= 1'b0;
            warn_reg <= 1'b1;
            // Pin released during reset so the board pull decides its level
            oe_reg <= 1'b0;
            pdack_reg <= 1'b0;
            s5_reg <= 1'b0;
        end else begin
            dsi_reg <= dsi_next;
            oe_reg <= 1'b1;
            warn_reg <= shared_next;
            pdack_reg <= pdack_level;
            s5_reg <= s5_next;
        end
    end

    // ==========================================================
    // Status outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wake_serviced <= 1'b0;
            flash_share_request <= 1'b0;
            internal_reset <= 1'b1;
            sleep_exit_done <= 1'b0;
            sleep_state <= 3'h0;
        end else begin
            wake_serviced <= wake_next;
            flash_share_request <= flash_next;
            internal_reset <= int_rst_next;
            sleep_exit_done <= exit_done_next;
            sleep_state <= state_code;
        end
    end
    // Pins come straight from the output flops
    assign link.deep_sleep_indicator_n = dsi_reg;
    assign link.suspend_warning_n = warn_reg;
    assign link.suspend_warning_oe = oe_reg;
    assign link.engine_powerdown_ack = pdack_reg;
    assign link.soft_off_power_control_n = s5_reg;
endmodule
`default_nettype wire

// ===== dv/power_handshake_sva.sv
// Concurrent checks on the pins joining the hub and controller ends
`timescale 1ns/100ps
`default_nettype none
module power_handshake_sva (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic deep_sleep_indicator_n,
    input wire logic suspend_warning_n,
    input wire logic suspend_warning_oe,
    input wire logic suspend_acknowledge_n,
    input wire logic rtc_buffered_clock_out
);
    wire rtc = rtc_buffered_clock_out;
    wire warn_n = suspend_warning_n;
    wire ack_n = suspend_acknowledge_n;
    wire ind_n = deep_sleep_indicator_n;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Handshake steps
    sequence acked_s;
        !warn_n && !ack_n;
    endsequence
    sequence still_up_s;
        ind_n[*3];
    endsequence
    rtc_high_a: assert property ($rose(rtc) |=> rtc[*7] ##1 !rtc)
        else $error("suspend clock high phase wrong");
    rtc_low_a: assert property ($fell(rtc) |=> !rtc[*7] ##1 rtc)
        else $error("suspend clock low phase wrong");
    deep_entry_a: assert property ($fell(ind_n) |-> acked_s)
        else $error("indicator fell without acknowledged warning");
    warn_first_a: assert property ($fell(warn_n) |-> still_up_s)
        else $error("indicator dropped too soon after warning");
    ack_match_a: assert property ($fell(ack_n) |-> !warn_n)
        else $error("acknowledge fell while warning high");
    ack_release_a: assert property ($rose(ack_n) |-> warn_n)
        else $error("acknowledge rose while warning low");
    exit_warn_a: assert property ($rose(ind_n) |-> ##[0:4] warn_n)
        else $error("warning still low after deep exit");
    pin_drive_a: assert property (!$past(sys_rst) |-> suspend_warning_oe)
        else $error("shared pin not driven");
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Bench joining both design ends through the handshake interface
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sup = 1'b1, espi = 1'b1, enter = 1'b0, soft_off = 1'b0, eng_n = 1'b1;
    logic needs = 1'b1, wake = 1'b0, bypass = 1'b0, hold = 1'b0, pgood = 1'b0, button = 1'b0;
    logic serviced, flash_req, int_rst, loss, wup, prim;
    logic loss_seen = 1'b0, wake_seen = 1'b0;
    logic [2:0] st;
    int num_errors = 0, tests_run = 0, cycles = 0;
    power_handshake_if link ();
    power_hub_end #(.DEBOUNCE_LAST(power_handshake_pkg::DEBOUNCE_LAST)) power_hub_end_inst (
        .core_clk(core_clk),
        .sys_rst(sys_rst), .link(link), .deep_sleep_supported(sup), .espi_enabled(espi),
        .enter_deep_sleep(enter), .soft_off_state(soft_off), .engine_sleep_control_n(eng_n),
        .engine_needs_primary(needs), .wake_event(wake), .wake_serviced(serviced),
        .flash_share_request(flash_req), .internal_reset(int_rst), .sleep_exit_done(),
        .sleep_state(st));
    power_controller_end power_controller_end_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .link(link), .deep_sleep_supported(sup), .handshake_bypass(bypass),
        .hold_exit(hold), .power_good_in(pgood), .reset_button(button),
        .prepare_power_loss(loss), .prepare_wake(wup), .primary_power_enable(prim));
    power_handshake_sva power_handshake_sva_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .deep_sleep_indicator_n(link.deep_sleep_indicator_n),
        .suspend_warning_n(link.suspend_warning_n),
        .suspend_warning_oe(link.suspend_warning_oe),
        .suspend_acknowledge_n(link.suspend_acknowledge_n),
        .rtc_buffered_clock_out(link.rtc_buffered_clock_out));
    always #5 core_clk = ~core_clk;
    // ==========================================
    // Pulse capture and hang guard
    always @(posedge core_clk) begin
        loss_seen <= loss_seen | loss;
        wake_seen <= wake_seen | wup;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic check_bit(input string nm, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic check_state(input string nm, input logic [2:0] exp);
        tests_run++;
        if (st !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, st);
        end
    endtask
    task automatic wait_state(input string nm, input logic [2:0] exp, input int lim);
        int n;
        n = 0;
        while (st !== exp && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        check_state(nm, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial begin
        idle(7);
        sys_rst = 1'b0;
        idle(20);
        check_state("no power good", 3'h5);
        pgood = 1'b1;
        wait_state("powered", 3'h0, 40);
        check_bit("int reset", 1'b0, int_rst);
        $display("test power good end");
        enter = 1'b1;
        wait_state("warn", 3'h1, 10);
        wake = 1'b1;
        idle(3);
        check_bit("wake unacked", 1'b0, serviced);
        wait_state("deep", 3'h2, 80);
        idle(2);
        check_bit("indicator", 1'b0, link.deep_sleep_indicator_n);
        check_bit("loss prep", 1'b1, loss_seen);
        hold = 1'b1;
        eng_n = 1'b0;
        enter = 1'b0;
        wait_state("holdoff", 3'h4, 80);
        idle(30);
        check_state("held", 3'h4);
        check_bit("flash share", 1'b0, flash_req);
        espi = 1'b0;
        idle(2);
        check_bit("flash share espi off", 1'b1, flash_req);
        check_state("held espi off", 3'h4);
        check_bit("wake prep", 1'b1, wake_seen);
        hold = 1'b0;
        eng_n = 1'b1;
        wait_state("exited", 3'h0, 40);
        check_bit("flash idle", 1'b0, flash_req);
        check_bit("indicator", 1'b1, link.deep_sleep_indicator_n);
        check_bit("wake", 1'b1, serviced);
        $display("test deep cycle end");
        sup = 1'b0;
        needs = 1'b0;
        soft_off = 1'b1;
        enter = 1'b1;
        idle(30);
        check_state("refused", 3'h0);
        check_bit("pd ack", 1'b1, link.engine_powerdown_ack);
        check_bit("pin", 1'b1, link.shared_pin);
        check_bit("soft off", 1'b0, link.soft_off_power_control_n);
        needs = 1'b1;
        soft_off = 1'b0;
        idle(5);
        check_bit("pd ack", 1'b0, link.engine_powerdown_ack);
        check_bit("pin", 1'b0, link.shared_pin);
        check_bit("soft off", 1'b1, link.soft_off_power_control_n);
        idle(30);
        check_bit("no ack change", 1'b1, link.suspend_acknowledge_n);
        $display("test unsupported end");
        enter = 1'b0;
        sup = 1'b1;
        bypass = 1'b1;
        idle(5);
        enter = 1'b1;
        wait_state("bypass deep", 3'h2, 12);
        check_bit("tied ack", 1'b0, link.suspend_acknowledge_n);
        enter = 1'b0;
        wait_state("bypass exit", 3'h0, 60);
        $display("test bypass end");
        button = 1'b1;
        idle(2);
        button = 1'b0;
        idle(40);
        check_state("glitch", 3'h0);
        button = 1'b1;
        wait_state("button", 3'h5, 60);
        check_bit("int reset", 1'b1, int_rst);
        button = 1'b0;
        wait_state("released", 3'h0, 80);
        $display("test reset button end");
        end_sim();
    end
endmodule
`default_nettype wire
